// ==== dscg_defines.vh ====
// constants for the deep-sleep clock gate block
`ifndef DSCG_DEFINES_VH
`define DSCG_DEFINES_VH
// ==========================================
// register byte addresses
`define DSCG_RUN_GATE_OFS      12'h104
`define DSCG_SLEEP_GATE_OFS    12'h114
`define DSCG_DEEP_GATE_OFS     12'h124
`define DSCG_RUN_CFG_OFS       12'h060
`define DSCG_INT_STAT_OFS      12'h200
`define DSCG_INT_MASK_OFS      12'h204
`define DSCG_FAULT_ADDR_OFS    12'h208
// ==========================================
// field layout
`define DSCG_GATE_MASK         32'h000F5017
`define DSCG_GATE_RESET        32'h00000000
`define DSCG_ACG_BIT           27
`define DSCG_CFG_RESET         32'h00000000
`define DSCG_NUM_UNITS         10
// ==========================================
// power states
`define DSCG_PWR_RUN           2'h0
`define DSCG_PWR_SLEEP         2'h1
`define DSCG_PWR_DEEP          2'h2
// ==========================================
// interrupt status bits
`define DSCG_EVT_FAULT         0
`define DSCG_EVT_CHANGE        1
`define DSCG_EVT_WIDTH         2
`define DSCG_UNMAPPED_DATA     32'h00000000
`endif

// ==== dscg_gate_sel.v ====
// selection of the active gating word from the power state
`timescale 1ns/1ps
`default_nettype none
`include "dscg_defines.vh"
module dscg_gate_sel (
   input  wire [31:0] run_gate,
   input  wire [31:0] sleep_gate,
   input  wire [31:0] deep_gate,
   input  wire [1:0]  pwr_state,
   input  wire        auto_gate,
   output reg  [31:0] active_gate
);
   // ==========================================
   // select
   always @* begin
      active_gate = run_gate;
      if (auto_gate && pwr_state == `DSCG_PWR_SLEEP) begin
         active_gate = sleep_gate;
      end else if (auto_gate && pwr_state == `DSCG_PWR_DEEP) begin
         active_gate = deep_gate;
      end
   end
endmodule // dscg_gate_sel
`default_nettype wire

// ==== dscg_unit_map.v ====
// maps the 32-bit gating word onto one enable per peripheral
`timescale 1ns/1ps
`default_nettype none
`include "dscg_defines.vh"
module dscg_unit_map (
   input  wire [31:0] gate_word,
   output wire [9:0]  unit_en
);
   // order: async_serial0_gate..2, sync_serial0_gate, twowire0_gate, twowire1_gate, gptimer0_gate..3
   localparam [319:0] BIT_POS = {32'd19, 32'd18, 32'd17, 32'd16, 32'd14,
                                 32'd12, 32'd4, 32'd2, 32'd1, 32'd0};
   genvar g;
   generate
      for (g = 0; g < 10; g = g + 1) begin : g_unit
         assign unit_en[g] = gate_word[BIT_POS[g*32 +: 5]];
      end
   endgenerate
endmodule // dscg_unit_map
`default_nettype wire

// ==== dscg_top.v ====
// deep-sleep clock gate register block with run/sleep companions
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "dscg_defines.vh"
module dscg_top (
   input  wire        clk_sys,
   input  wire        rst,
   // avalon-mm slave
   input  wire [11:0] avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   // power state from the power manager
   input  wire [1:0]  pwr_state,
   // peripheral bus access check
   input  wire        periph_req,
   input  wire [3:0]  periph_sel,
   output wire        periph_fault,
   // clock enables, one per unit, and the interrupt request
   output wire        async_serial0_gate,
   output wire        async_serial1_gate,
   output wire        async_serial2_gate,
   output wire        sync_serial0_gate,
   output wire        twowire0_gate,
   output wire        twowire1_gate,
   output wire        gptimer0_gate,
   output wire        gptimer1_gate,
   output wire        gptimer2_gate,
   output wire        gptimer3_gate,
   output wire        irq
);
   // ==========================================
   // registers
   reg  [31:0] run_clock_gate_1_r;
   reg  [31:0] sleep_clock_gate_1_r;
   reg  [31:0] deep_sleep_clock_gate_1_r;
   reg  [31:0] run_clock_config_r;
   reg  [1:0]  int_stat_r;
   reg  [1:0]  int_mask_r;
   reg  [3:0]  fault_sel_r;
   reg         ack_r;
   wire [31:0] active_gate;
   wire [9:0]  unit_en;
   wire [31:0] be_mask;
   wire        acc;
   wire        hit_run;
   wire        hit_sleep;
   wire        hit_deep;
   wire        hit_cfg;
   wire        hit_stat;
   wire        hit_mask;
   wire        fault_evt;
   reg  [9:0]  unit_en_q;
   wire        change_evt;
   reg  [1:0]  set_evt;

   assign be_mask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign acc       = avs_read | avs_write;
   // one wait state: each access completes on the edge where ack_r is high
   assign avs_waitrequest = acc & ~ack_r;
   assign hit_run   = avs_address == `DSCG_RUN_GATE_OFS;
   assign hit_sleep = avs_address == `DSCG_SLEEP_GATE_OFS;
   assign hit_deep  = avs_address == `DSCG_DEEP_GATE_OFS;
   assign hit_cfg   = avs_address == `DSCG_RUN_CFG_OFS;
   assign hit_stat  = avs_address == `DSCG_INT_STAT_OFS;
   assign hit_mask  = avs_address == `DSCG_INT_MASK_OFS;

   // ==========================================
   // bus slave
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= acc & ~ack_r;
      end
   end

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         run_clock_gate_1_r        <= `DSCG_GATE_RESET;
         sleep_clock_gate_1_r      <= `DSCG_GATE_RESET;
         deep_sleep_clock_gate_1_r <= `DSCG_GATE_RESET;
         run_clock_config_r        <= `DSCG_CFG_RESET;
         int_mask_r                <= 2'h0;
      end else if (avs_write && ack_r) begin
         // masking keeps reserved positions of the three gate registers at zero; run_clock_config_r keeps all 32 bits
         if (hit_run) begin
            run_clock_gate_1_r <= ((run_clock_gate_1_r & ~be_mask) | (avs_writedata & be_mask))
                                  & `DSCG_GATE_MASK;
         end else if (hit_sleep) begin
            sleep_clock_gate_1_r <= ((sleep_clock_gate_1_r & ~be_mask) | (avs_writedata & be_mask))
                                    & `DSCG_GATE_MASK;
         end else if (hit_deep) begin
            deep_sleep_clock_gate_1_r <= ((deep_sleep_clock_gate_1_r & ~be_mask) | (avs_writedata & be_mask))
                                         & `DSCG_GATE_MASK;
         end else if (hit_cfg) begin
            run_clock_config_r <= (run_clock_config_r & ~be_mask) | (avs_writedata & be_mask);
         end else if (hit_mask) begin
            if (avs_byteenable[0]) begin
               int_mask_r <= avs_writedata[1:0];
            end
         end
      end
   end

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read && !ack_r) begin
         if (hit_run) begin
            avs_readdata <= run_clock_gate_1_r;
         end else if (hit_sleep) begin
            avs_readdata <= sleep_clock_gate_1_r;
         end else if (hit_deep) begin
            avs_readdata <= deep_sleep_clock_gate_1_r;
         end else if (hit_cfg) begin
            avs_readdata <= run_clock_config_r;
         end else if (hit_stat) begin
            avs_readdata <= {30'h0, int_stat_r};
         end else if (hit_mask) begin
            avs_readdata <= {30'h0, int_mask_r};
         end else if (avs_address == `DSCG_FAULT_ADDR_OFS) begin
            avs_readdata <= {28'h0000000, fault_sel_r};
         end else begin
            avs_readdata <= `DSCG_UNMAPPED_DATA;
         end
      end
   end

   // ==========================================
   // gate selection and outputs
   dscg_gate_sel u_sel (
      .run_gate    (run_clock_gate_1_r),
      .sleep_gate  (sleep_clock_gate_1_r),
      .deep_gate   (deep_sleep_clock_gate_1_r),
      .pwr_state   (pwr_state),
      .auto_gate   (run_clock_config_r[`DSCG_ACG_BIT]),
      .active_gate (active_gate)
   );

   dscg_unit_map u_map (
      .gate_word (active_gate),
      .unit_en   (unit_en)
   );

   assign async_serial0_gate = unit_en[0];
   assign async_serial1_gate = unit_en[1];
   assign async_serial2_gate = unit_en[2];
   assign sync_serial0_gate  = unit_en[3];
   assign twowire0_gate      = unit_en[4];
   assign twowire1_gate      = unit_en[5];
   assign gptimer0_gate      = unit_en[6];
   assign gptimer1_gate      = unit_en[7];
   assign gptimer2_gate      = unit_en[8];
   assign gptimer3_gate      = unit_en[9];

   // ==========================================
   // bus fault on access to a stopped unit
   // combinational so the fabric can end the access in the same cycle
   assign periph_fault = periph_req & (periph_sel < 4'hA) & ~unit_en[periph_sel];
   assign fault_evt    = periph_fault;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         fault_sel_r <= 4'h0;
      end else if (fault_evt) begin
         fault_sel_r <= periph_sel;
      end
   end

   // ==========================================
   // interrupts
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         unit_en_q <= 10'h000;
      end else begin
         unit_en_q <= unit_en;
      end
   end
   assign change_evt = unit_en_q != unit_en;

   always @* begin
      set_evt = 2'h0;
      set_evt[`DSCG_EVT_FAULT]  = fault_evt;
      set_evt[`DSCG_EVT_CHANGE] = change_evt;
   end

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         int_stat_r <= 2'h0;
      end else if (avs_read && ack_r && hit_stat) begin
         // new event in the clearing cycle survives
         int_stat_r <= set_evt;
      end else begin
         int_stat_r <= int_stat_r | set_evt;
      end
   end

   assign irq = |(int_stat_r & int_mask_r);
endmodule // dscg_top
`default_nettype wire

// ==== dscg_top_monitor.sv ====
// concurrent checks on the deep-sleep clock gate ports
`timescale 1ns/1ps
`default_nettype none
module dscg_top_monitor (
   input wire        clk_sys,
   input wire        rst,
   input wire [11:0] avs_address,
   input wire        avs_read,
   input wire        avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0]  avs_byteenable,
   input wire [31:0] avs_readdata,
   input wire        avs_waitrequest,
   input wire [1:0]  pwr_state,
   input wire        periph_req,
   input wire [3:0]  periph_sel,
   input wire        periph_fault,
   input wire        async_serial0_gate,
   input wire        async_serial1_gate,
   input wire        async_serial2_gate,
   input wire        sync_serial0_gate,
   input wire        twowire0_gate,
   input wire        twowire1_gate,
   input wire        gptimer0_gate,
   input wire        gptimer1_gate,
   input wire        gptimer2_gate,
   input wire        gptimer3_gate
);
   // ==========================================
   // checks
   wire [9:0] en = {gptimer3_gate, gptimer2_gate, gptimer1_gate, gptimer0_gate, twowire1_gate, twowire0_gate,
                    sync_serial0_gate, async_serial2_gate, async_serial1_gate, async_serial0_gate};
   wire [9:0] wmap = {avs_writedata[19:16], avs_writedata[14], avs_writedata[12], avs_writedata[4], avs_writedata[2:0]};
   wire       wdone = avs_write & ~avs_waitrequest & (avs_byteenable == 4'hF);
   wire       gate_rd = avs_read & ~avs_waitrequest & (avs_address[7:0] == 8'h24 || avs_address[7:0] == 8'h14
                        || avs_address[7:0] == 8'h04) & (avs_address[11:8] == 4'h1);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_fault_gated: assert property (periph_req && periph_sel < 4'hA |-> periph_fault == !en[periph_sel])
      else $error("fault does not follow gate");
   a_fault_idle: assert property (!periph_req |-> !periph_fault)
      else $error("fault without access");
   a_reset_off: assert property ($fell(rst) |-> en == 10'h000)
      else $error("gate on after reset");
   a_gate_cause: assert property ($changed(en) |-> $past(avs_write && !avs_waitrequest) || $changed(pwr_state))
      else $error("gate moved without cause");
   a_run_map: assert property (wdone && avs_address == 12'h104 && pwr_state == 2'h0 ##1 pwr_state == 2'h0 |-> en == $past(wmap))
      else $error("gate bit map wrong");
   a_run_ignores: assert property (wdone && (avs_address == 12'h124 || avs_address == 12'h114) && pwr_state == 2'h0
      ##1 pwr_state == 2'h0 |-> $stable(en))
      else $error("idle register steered gates");
   a_reserved_zero: assert property (gate_rd |-> (avs_readdata & 32'hFFF0AFE8) == 32'h0)
      else $error("reserved bit read set");
   a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("wait state count wrong");
endmodule // dscg_top_monitor
bind dscg_top dscg_top_monitor u_mon (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_byteenable, .avs_readdata, .avs_waitrequest, .pwr_state, .periph_req, .periph_sel, .periph_fault,
   .async_serial0_gate, .async_serial1_gate, .async_serial2_gate, .sync_serial0_gate, .twowire0_gate,
   .twowire1_gate, .gptimer0_gate, .gptimer1_gate, .gptimer2_gate, .gptimer3_gate);
`default_nettype wire

// ==== dscg_top_test.sv ====
// self-checking bench for the deep-sleep clock gate block
`timescale 1ns/1ps
`default_nettype none
module dscg_top_test;
   // ==========================================
   // stimulus and expectation queue
   logic        clk_sys, rst, avs_read, avs_write, periph_req, chk, avs_waitrequest, periph_fault, irq;
   logic [11:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, d, w, r;
   logic [3:0]  periph_sel, s;
   logic [1:0]  pwr_state;
   logic [9:0]  m;
   wire  [9:0]  en;
   logic [63:0] q[$];
   logic [63:0] e;
   int          failures, checked, cyc;
   dscg_top dut (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF),
      .avs_readdata, .avs_waitrequest, .pwr_state, .periph_req, .periph_sel, .periph_fault,
      .async_serial0_gate(en[0]), .async_serial1_gate(en[1]), .async_serial2_gate(en[2]), .sync_serial0_gate(en[3]),
      .twowire0_gate(en[4]), .twowire1_gate(en[5]), .gptimer0_gate(en[6]), .gptimer1_gate(en[7]),
      .gptimer2_gate(en[8]), .gptimer3_gate(en[9]), .irq);
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   function automatic logic [9:0] mp(input logic [31:0] v);
      return {v[19:16], v[14], v[12], v[4], v[2:0]};
   endfunction
   // one avalon access; request held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= wd;
      do @(posedge clk_sys); while (avs_waitrequest);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] mk);
      q.push_back({mk, x});
      bus(1'b0, a, 32'h0);
   endtask
   // probe word is {irq, fault, enables}; mask drops what a case cannot predict
   task automatic pr(input logic [11:0] x, input logic [11:0] mk);
      q.push_back({20'h0, mk, 20'h0, x});
      @(posedge clk_sys);
      chk <= 1'b1;
      @(posedge clk_sys);
      chk <= 1'b0;
   endtask
   task automatic print_verdict;
      if (failures == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ==========================================
   // output watcher and timeout
   always @(posedge clk_sys) begin
      cyc++;
      if ((avs_read && !avs_waitrequest) || chk) begin
         e = q.pop_front();
         r = avs_read ? avs_readdata : {20'h0, irq, periph_fault, en};
         checked++;
         if ((r & e[63:32]) !== (e[31:0] & e[63:32])) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, r, e[31:0]);
         end
      end
      if (cyc == 3000) begin
         failures++;
         print_verdict();
      end
   end
   // ==========================================
   // scenarios
   initial begin
      // reset must be high from time zero, idle requests low
      rst = 1'b1;
      {avs_read, avs_write, periph_req, chk} = 4'h0;
      failures = 0;
      checked = 0;
      cyc = 0;
      {avs_address, avs_writedata, periph_sel, pwr_state} = 0;
      d = $urandom(4059);
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      rd(12'h124, 32'h0, 32'hFFFFFFFF);
      pr(12'h0, 12'h3FF);
      bus(1'b1, 12'h060, 32'h08000000);
      pwr_state <= 2'h2;
      repeat (6) begin
         d = $urandom;
         m = mp(d);
         s = 4'($urandom % 10);
         periph_sel <= s;
         periph_req <= 1'b1;
         bus(1'b1, 12'h124, d);
         rd(12'h124, d & 32'h000F5017, 32'hFFFFFFFF);
         pr({1'b0, ~m[s], m}, 12'h7FF);
      end
      periph_req <= 1'b0;
      pwr_state <= 2'h0;
      d = $urandom;
      w = $urandom;
      bus(1'b1, 12'h104, d);
      bus(1'b1, 12'h114, w);
      rd(12'h104, d & 32'h000F5017, 32'hFFFFFFFF);
      pr({2'b0, mp(d)}, 12'h3FF);
      pwr_state <= 2'h1;
      pr({2'b0, mp(w)}, 12'h3FF);
      bus(1'b1, 12'h060, 32'h0);
      pr({2'b0, mp(d)}, 12'h3FF);
      bus(1'b1, 12'h300, $urandom);
      rd(12'h300, 32'h0, 32'hFFFFFFFF);
      rd(12'h200, 32'h0, 32'h0);
      bus(1'b1, 12'h204, 32'h1);
      bus(1'b1, 12'h104, 32'h0);
      periph_sel <= 4'h5;
      periph_req <= 1'b1;
      pr(12'hC00, 12'hFFF);
      periph_req <= 1'b0;
      rd(12'h200, 32'h1, 32'h1);
      rd(12'h208, 32'h5, 32'hFFFFFFFF);
      pr(12'h0, 12'h800);
      bus(1'b1, 12'h204, 32'h0);
      periph_req <= 1'b1;
      pr(12'h400, 12'hFFF);
      periph_req <= 1'b0;
      // second reset in mid-run must drop every gate again
      bus(1'b1, 12'h104, 32'hFFFFFFFF);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      rd(12'h104, 32'h0, 32'hFFFFFFFF);
      pr(12'h0, 12'h3FF);
      print_verdict();
   end
endmodule // dscg_top_test
`default_nettype wire
